// >>> pkg/lvtc_pkg.sv
// Constants, register map and bus carriers for the drive-voltage temperature compensation block.
// Assumes a 250 MHz aclk, an AXI4-Lite master and a one-cycle frame_tick from the frame timer.
package lvtc_pkg;

	// Register byte addresses.
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_SLOPE   = 8'h04;
	localparam logic [7:0] ADDR_VPROG   = 8'h08;
	localparam logic [7:0] ADDR_TEMP    = 8'h0C;
	localparam logic [7:0] ADDR_COMP    = 8'h10;

	// Control bit positions and slope field layout.
	localparam int CTRL_MEASURE_BIT  = 0;
	localparam int CTRL_FILTER_BIT   = 1;
	localparam int CTRL_COMP_BIT     = 2;
	localparam int SLOPE_FIELD_W     = 3;
	localparam int NUM_REGIONS       = 4;

	// Reset values.
	localparam logic [2:0] SLOPE_RESET     = 3'h0;
	localparam logic [7:0] VPROG_RESET     = 8'h00;
	localparam logic [7:0] FILTER_RESET    = 8'h40;

	// Conversion timing.
	localparam int CLK_PERIOD_PS     = 4000;
	localparam int CONV_TIME_US      = 5000;
	// Window in clock cycles: nanoseconds of the window over nanoseconds per clock.
	localparam int CONV_CYCLES       = (CONV_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);
	localparam int INTERVAL_FRAMES   = 200;

	// Temperature breakpoints in sixteenths of a degree.
	localparam logic signed [13:0] T16_OFFSET = 14'sh0280;
	localparam logic signed [13:0] T16_SCALE  = 14'sh000F;
	localparam logic signed [13:0] T16_M40    = -14'sh0280;
	localparam logic signed [13:0] T16_M10    = -14'sh00A0;
	localparam logic signed [13:0] T16_P20    = 14'sh0140;
	localparam logic signed [13:0] T16_P50    = 14'sh0320;
	localparam logic signed [13:0] T16_P80    = 14'sh0500;
	localparam logic signed [20:0] SPAN16     = 21'sh001E0;
	localparam logic signed [20:0] STEP16     = 21'sh001E0;

	// AXI4-Lite response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum {
		ST_IDLE,
		ST_CONVERT,
		ST_WAIT
	} lvtc_state_t;

	// Master to slave channel signals.
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} lvtc_axil_req_t;

	// Slave to master channel signals.
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} lvtc_axil_rsp_t;

	// Slope selector to mV per degree.
	function automatic logic signed [6:0] slope_mv(input logic [2:0] sel);
		case (sel)
			3'h1:    slope_mv = -7'sd4;
			3'h2:    slope_mv = -7'sd8;
			3'h3:    slope_mv = -7'sd16;
			3'h4:    slope_mv = -7'sd40;
			3'h5:    slope_mv = 7'sd4;
			3'h6:    slope_mv = 7'sd8;
			3'h7:    slope_mv = 7'sd16;
			default: slope_mv = 7'sd0;
		endcase
	endfunction : slope_mv

endpackage : lvtc_pkg

// >>> logic/lvtc_top.sv
// Temperature readout, jitter filter and drive-voltage offset with an AXI4-Lite register file.
// Assumes sensor_code is valid at the end of a conversion window and frame_tick pulses per frame.
`timescale 1ns/100ps
module lvtc_top
	import lvtc_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYCLES
) (
	input  wire logic           aclk,
	input  wire logic           aresetn,
	input  wire lvtc_axil_req_t axil_req,
	output lvtc_axil_rsp_t      axil_rsp,
	input  wire logic [7:0]     sensor_code,
	input  wire logic           frame_tick,
	input  wire logic           external_supply,
	output logic                sensor_enable,
	output logic [7:0]          temperature_offset_code,
	output logic [7:0]          drive_voltage_code
);

	// Register file state.
	logic                   measure_enable_q;
	logic                   temp_filter_enable_q;
	logic                   compensation_enable_q;
	logic [11:0]            slope_q;
	logic [7:0]             programmed_voltage_code_q;

	// Bus slave state.
	logic                   aw_rdy_q;
	logic                   w_rdy_q;
	logic [7:0]             awaddr_q;
	logic [31:0]            wdata_q;
	logic [3:0]             wstrb_q;
	logic                   bvalid_q;
	logic [1:0]             bresp_q;
	logic                   ar_rdy_q;
	logic                   rvalid_q;
	logic [31:0]            rdata_q;
	logic [1:0]             rresp_q;

	// Measurement state.
	lvtc_state_t            state_q;
	logic [31:0]            cyc_q;
	logic [7:0]             frames_q;
	logic                   sensor_en_q;
	logic [7:0]             temperature_code_q;
	logic                   temp_valid_q;
	logic                   conv_done_q;
	logic [7:0]             filt_q;
	logic [7:0]             sel_temp_q;
	logic [7:0]             offset_q;
	logic [7:0]             target_q;

	// Combinational helpers.
	logic                   do_write;
	logic                   aw_hs;
	logic                   w_hs;
	logic signed [6:0]      sf [NUM_REGIONS];
	logic signed [13:0]     t16;
	logic signed [20:0]     off16;
	logic signed [20:0]     steps;
	logic signed [9:0]      sum;

	assign aw_hs    = axil_req.awvalid && aw_rdy_q;
	assign w_hs     = axil_req.wvalid && w_rdy_q;
	assign do_write = !aw_rdy_q && !w_rdy_q && !bvalid_q;

	// Write address and data are captured independently and released after the response.
	// Holding both ready lines low until the response is taken keeps one write in flight.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_rdy_q <= 1'b1;
			w_rdy_q  <= 1'b1;
			awaddr_q <= 8'h00;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else begin
			if (aw_hs) begin
				aw_rdy_q <= 1'b0;
				awaddr_q <= axil_req.awaddr;
			end
			if (w_hs) begin
				w_rdy_q <= 1'b0;
				wdata_q <= axil_req.wdata;
				wstrb_q <= axil_req.wstrb;
			end
			if (bvalid_q && axil_req.bready) begin
				aw_rdy_q <= 1'b1;
				w_rdy_q  <= 1'b1;
			end
		end
	end

	// Write response; unmapped or read-only addresses answer with a slave error.
	// The response follows both captures by one cycle, together with the register update.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (awaddr_q == ADDR_CTRL || awaddr_q == ADDR_SLOPE ||
				awaddr_q == ADDR_VPROG) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_q && axil_req.bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Writable registers honour the byte strobes.
	// Writes to read-only or unmapped offsets fall into the default branch and change nothing.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			measure_enable_q          <= 1'b0;
			temp_filter_enable_q      <= 1'b0;
			compensation_enable_q     <= 1'b0;
			slope_q                   <= {NUM_REGIONS{SLOPE_RESET}};
			programmed_voltage_code_q <= VPROG_RESET;
		end else if (do_write) begin
			case (awaddr_q)
				ADDR_CTRL: begin
					if (wstrb_q[0]) begin
						measure_enable_q      <= wdata_q[CTRL_MEASURE_BIT];
						temp_filter_enable_q  <= wdata_q[CTRL_FILTER_BIT];
						compensation_enable_q <= wdata_q[CTRL_COMP_BIT];
					end
				end
				ADDR_SLOPE: begin
					if (wstrb_q[0]) begin
						slope_q[7:0] <= wdata_q[7:0];
					end
					if (wstrb_q[1]) begin
						slope_q[11:8] <= wdata_q[11:8];
					end
				end
				ADDR_VPROG: begin
					if (wstrb_q[0]) begin
						programmed_voltage_code_q <= wdata_q[7:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Read channel; one beat answered the cycle after the address is taken.
	// Read data is frozen at address time, so a later status change cannot alter a pending beat.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_rdy_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end else if (axil_req.arvalid && ar_rdy_q) begin
			ar_rdy_q <= 1'b0;
			rvalid_q <= 1'b1;
			rresp_q  <= RESP_OKAY;
			case (axil_req.araddr)
				ADDR_CTRL:  rdata_q <= {29'h0, compensation_enable_q,
					temp_filter_enable_q, measure_enable_q};
				ADDR_SLOPE: rdata_q <= {20'h0_0000, slope_q};
				ADDR_VPROG: rdata_q <= {24'h00_0000, programmed_voltage_code_q};
				ADDR_TEMP:  rdata_q <= {15'h0, temp_valid_q, filt_q, temperature_code_q};
				ADDR_COMP:  rdata_q <= {16'h0000, target_q, offset_q};
				default: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && axil_req.rready) begin
			rvalid_q <= 1'b0;
			ar_rdy_q <= 1'b1;
		end
	end

	// Conversion sequencer: a fixed conversion window, then a wait counted in frames.
	// Counting frames rather than clocks makes the interval follow the frame frequency.
	// Clearing the measure enable abandons a window or a wait and returns to idle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q     <= ST_IDLE;
			cyc_q       <= 32'h0000_0000;
			frames_q    <= 8'h00;
			sensor_en_q <= 1'b0;
			conv_done_q <= 1'b0;
		end else begin
			conv_done_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (measure_enable_q) begin
						state_q     <= ST_CONVERT;
						cyc_q       <= 32'h0000_0000;
						sensor_en_q <= 1'b1;
					end
				end
				ST_CONVERT: begin
					if (!measure_enable_q) begin
						state_q     <= ST_IDLE;
						sensor_en_q <= 1'b0;
					end else if (cyc_q == 32'(CONV_CYC - 1)) begin
						state_q     <= ST_WAIT;
						frames_q    <= 8'h00;
						sensor_en_q <= 1'b0;
						conv_done_q <= 1'b1;
					end else begin
						cyc_q <= cyc_q + 32'h0000_0001;
					end
				end
				ST_WAIT: begin
					if (!measure_enable_q) begin
						state_q <= ST_IDLE;
					end else if (frame_tick) begin
						if (frames_q == 8'(INTERVAL_FRAMES - 1)) begin
							state_q     <= ST_CONVERT;
							cyc_q       <= 32'h0000_0000;
							sensor_en_q <= 1'b1;
						end else begin
							frames_q <= frames_q + 8'h01;
						end
					end
				end
				default: begin
					state_q     <= ST_IDLE;
					sensor_en_q <= 1'b0;
				end
			endcase
		end
	end

	// Raw code is latched at the end of each conversion window.
	// The latch condition mirrors the sequencer's last window cycle exactly.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			temperature_code_q <= 8'h00;
			temp_valid_q       <= 1'b0;
		end else if (state_q == ST_CONVERT && measure_enable_q &&
			cyc_q == 32'(CONV_CYC - 1)) begin
			temperature_code_q <= sensor_code;
			temp_valid_q       <= 1'b1;
		end
	end

	// Filter steps one LSB toward the raw code only when it differs by two or more.
	// The one-code dead band stops single-LSB jitter from reaching the offset path.
	// Guards at the ends of the code range keep the compare terms from wrapping.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			filt_q <= FILTER_RESET;
		end else if (conv_done_q) begin
			if (temperature_code_q > filt_q + 8'h01 && filt_q != 8'hFF) begin
				filt_q <= filt_q + 8'h01;
			end else if (temperature_code_q + 8'h01 < filt_q && temperature_code_q != 8'hFF) begin
				filt_q <= filt_q - 8'h01;
			end
		end
	end

	// Selected temperature feeds the offset path.
	// Registering the selection breaks the path from the filter into the offset arithmetic.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_temp_q <= FILTER_RESET;
		end else begin
			sel_temp_q <= temp_filter_enable_q ? filt_q : temperature_code_q;
		end
	end

	// Slope selectors decoded per region.
	// Each region decodes its own field, so the four slopes are fully independent.
	for (genvar r = 0; r < NUM_REGIONS; r++) begin : g_slope
		assign sf[r] = slope_mv(slope_q[r*SLOPE_FIELD_W +: SLOPE_FIELD_W]);
	end

	// Temperature in sixteenths of a degree: code times 15 minus 640.
	// Working in sixteenths keeps every code step exact in integer arithmetic.
	assign t16 = $signed({6'h00, sel_temp_q}) * T16_SCALE - T16_OFFSET;

	// Offset in mV times 16, per region, held at the 80 degree value above.
	// Neighbouring regions agree at each breakpoint, so the offset has no jump there.
	always_comb begin
		if (t16 <= T16_M40) begin
			off16 = SPAN16 * 21'(sf[0]) + SPAN16 * 21'(sf[1]);
		end else if (t16 <= T16_M10) begin
			off16 = 21'(T16_M10 - t16) * 21'(sf[0]) + SPAN16 * 21'(sf[1]);
		end else if (t16 <= T16_P20) begin
			off16 = 21'(T16_P20 - t16) * 21'(sf[1]);
		end else if (t16 <= T16_P50) begin
			off16 = 21'(t16 - T16_P20) * 21'(sf[2]);
		end else if (t16 < T16_P80) begin
			off16 = 21'(t16 - T16_P50) * 21'(sf[3]) + SPAN16 * 21'(sf[2]);
		end else begin
			off16 = SPAN16 * 21'(sf[3]) + SPAN16 * 21'(sf[2]);
		end
	end

	// Whole 30 mV steps, truncated toward zero.
	// Truncation toward zero keeps positive and negative offsets symmetric.
	assign steps = off16 / STEP16;

	// Offset gated by the enable and by an external supply.
	// An external supply overrides the enable, since there is no internal voltage to correct.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			offset_q <= 8'h00;
		end else if (!compensation_enable_q || external_supply) begin
			offset_q <= 8'h00;
		end else begin
			offset_q <= steps[7:0];
		end
	end

	// Programmed code plus signed offset.
	// Two guard bits hold the full sum so that saturation sees overflow and underflow.
	assign sum = $signed({2'b00, programmed_voltage_code_q}) +
		$signed({{2{offset_q[7]}}, offset_q});

	// Target saturates at both ends of the code range.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			target_q <= 8'h00;
		end else if (sum < 10'sd0) begin
			target_q <= 8'h00;
		end else if (sum > 10'sd255) begin
			target_q <= 8'hFF;
		end else begin
			target_q <= sum[7:0];
		end
	end

	// Outputs straight from flip-flops.
	// The bus response struct is built field by field from the slave registers.
	assign sensor_enable           = sensor_en_q;
	assign temperature_offset_code = offset_q;
	assign drive_voltage_code      = target_q;
	assign axil_rsp.awready        = aw_rdy_q;
	assign axil_rsp.wready         = w_rdy_q;
	assign axil_rsp.bvalid         = bvalid_q;
	assign axil_rsp.bresp          = bresp_q;
	assign axil_rsp.arready        = ar_rdy_q;
	assign axil_rsp.rvalid         = rvalid_q;
	assign axil_rsp.rdata          = rdata_q;
	assign axil_rsp.rresp          = rresp_q;

endmodule : lvtc_top

// >>> bench/lvtc_sva.sv
// Checker for the compensation block: bus answers, conversion timing, offset gating.
// Assumes it is bound to lvtc_top and sees only that module's ports.
`timescale 1ns/100ps
module lvtc_sva
	import lvtc_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYCLES
) (
	input wire logic           aclk,
	input wire logic           aresetn,
	input wire lvtc_axil_req_t axil_req,
	input wire lvtc_axil_rsp_t axil_rsp,
	input wire logic [7:0]     sensor_code,
	input wire logic           frame_tick,
	input wire logic           external_supply,
	input wire logic           sensor_enable,
	input wire logic [7:0]     temperature_offset_code,
	input wire logic [7:0]     drive_voltage_code
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [31:0] win_q;
	logic [15:0] tick_q;
	logic        seen_q;

	// Counts window cycles and the frame ticks seen since the last window closed.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			win_q  <= 32'h0;
			tick_q <= 16'h0;
			seen_q <= 1'b0;
		end else begin
			win_q  <= sensor_enable ? win_q + 32'h1 : 32'h0;
			tick_q <= sensor_enable ? 16'h0 : tick_q + {15'h0, frame_tick};
			seen_q <= seen_q | sensor_enable;
		end
	end

	sequence s_wr_taken;
		axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
	endsequence
	sequence s_rd_taken;
		axil_req.arvalid && axil_rsp.arready;
	endsequence

	a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !sensor_enable &&
		temperature_offset_code == 8'h00 && drive_voltage_code == 8'h00 && !axil_rsp.bvalid)
		else $error("outputs not quiet after reset");
	a_wr_answer: assert property (s_wr_taken |-> ##2 axil_rsp.bvalid)
		else $error("write response late");
	a_rd_answer: assert property (s_rd_taken |=> axil_rsp.rvalid)
		else $error("read data late");
	a_b_clear: assert property (axil_rsp.bvalid && axil_req.bready |=> !axil_rsp.bvalid)
		else $error("write response not cleared");
	a_r_clear: assert property (axil_rsp.rvalid && axil_req.rready |=> !axil_rsp.rvalid)
		else $error("read data not cleared");
	a_conv_len: assert property ($fell(sensor_enable) |-> win_q == 32'(CONV_CYC))
		else $error("conversion window length wrong");
	a_conv_interval: assert property ($rose(sensor_enable) && seen_q |->
		tick_q == 16'(INTERVAL_FRAMES))
		else $error("conversion interval wrong");
	a_ext_zero: assert property (external_supply [*4] |-> temperature_offset_code == 8'h00)
		else $error("offset applied with external supply");
endmodule : lvtc_sva

bind lvtc_top lvtc_sva #(.CONV_CYC(CONV_CYC)) i_sva (.aclk(aclk), .aresetn(aresetn),
	.axil_req(axil_req), .axil_rsp(axil_rsp), .sensor_code(sensor_code),
	.frame_tick(frame_tick), .external_supply(external_supply), .sensor_enable(sensor_enable),
	.temperature_offset_code(temperature_offset_code), .drive_voltage_code(drive_voltage_code));

// >>> bench/lvtc_tb_top.sv
// Self-checking bench for the compensation block, driven over its register bus.
// Assumes a short conversion window and a frame tick every eighth cycle.
`timescale 1ns/100ps
module lvtc_tb_top
	import lvtc_pkg::*;
;
	localparam int SLMV [8] = '{0, -4, -8, -16, -40, 4, 8, 16};
	logic           aclk = 1'b0;
	logic           aresetn = 1'b0;
	lvtc_axil_req_t req = '0;
	lvtc_axil_rsp_t rsp;
	logic [7:0]     sensor_code = 8'h00;
	logic           frame_tick = 1'b0;
	logic           external_supply = 1'b0;
	logic           sensor_enable;
	logic [7:0]     offs;
	logic [7:0]     drive;
	logic [2:0]     ft_q = 3'h0;
	logic [7:0]     raw = 8'h00;
	logic [7:0]     filt = 8'h40;
	logic [7:0]     vprog = 8'h00;
	logic           fen = 1'b0;
	logic           cen = 1'b0;
	int             sl [4] = '{0, 0, 0, 0};
	int             err_total = 0;
	int             checks = 0;
	logic [7:0]     codes [11] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60,
		8'h70, 8'h80, 8'h8C, 8'hFF};

	lvtc_top #(.CONV_CYC(16)) i_dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req),
		.axil_rsp(rsp), .sensor_code(sensor_code), .frame_tick(frame_tick),
		.external_supply(external_supply), .sensor_enable(sensor_enable),
		.temperature_offset_code(offs), .drive_voltage_code(drive));

	// Clock of 4 ns period.
	initial begin
		forever #2 aclk = ~aclk;
	end

	// Frame tick on every eighth cycle.
	always @(posedge aclk) begin
		ft_q <= ft_q + 3'h1;
		frame_tick <= (ft_q == 3'h7);
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : summarize

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp32

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		cmp32({24'h0, got}, {24'h0, exp});
	endtask : cmp8

	task automatic timed_out();
		cmp32(32'h0, 32'h1);
		summarize();
	endtask : timed_out

	// Write one word; valid signals drop once taken, bready stays up until the answer.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid === 1'b1) break;
		end
		req.bready <= 1'b0;
		if (i == 50) timed_out();
		cmp8({6'h0, rsp.bresp}, {6'h0, er});
	endtask : axi_wr

	// Read one word and compare data and response.
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int i;
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid === 1'b1) break;
		end
		req.rready <= 1'b0;
		if (i == 50) timed_out();
		cmp32(rsp.rdata, ed);
		cmp8({6'h0, rsp.rresp}, {6'h0, er});
	endtask : axi_rd

	// Offset steps from the selected code, region by region, in sixteenths of a degree.
	function automatic int exp_off(input int c);
		int t;
		int v;
		t = c * 15 - 640;
		if (t <= -640) v = 480 * sl[0] + 480 * sl[1];
		else if (t <= -160) v = (-160 - t) * sl[0] + 480 * sl[1];
		else if (t <= 320) v = (320 - t) * sl[1];
		else if (t <= 800) v = (t - 320) * sl[2];
		else if (t < 1280) v = (t - 800) * sl[3] + 480 * sl[2];
		else v = 480 * sl[3] + 480 * sl[2];
		return (cen && !external_supply) ? v / 480 : 0;
	endfunction : exp_off

	task automatic chk_out();
		int o;
		int d;
		o = exp_off(fen ? filt : raw);
		d = vprog + o;
		d = d < 0 ? 0 : (d > 255 ? 255 : d);
		cmp8(offs, 8'(o));
		cmp8(drive, 8'(d));
		axi_rd(ADDR_COMP, {16'h0, 8'(d), 8'(o)}, RESP_OKAY);
	endtask : chk_out

	task automatic cfg(input logic [2:0] ctl, input logic [11:0] slp, input logic [7:0] vp);
		// Slopes and drive code first, enables last: the first conversion that this starts
		// is still running when the next conv call arrives, so the model tracks it.
		axi_wr(ADDR_SLOPE, {20'h0, slp}, RESP_OKAY);
		axi_wr(ADDR_VPROG, {24'h0, vp}, RESP_OKAY);
		axi_wr(ADDR_CTRL, {29'h0, ctl}, RESP_OKAY);
		fen = ctl[CTRL_FILTER_BIT];
		cen = ctl[CTRL_COMP_BIT];
		vprog = vp;
		for (int k = 0; k < NUM_REGIONS; k++) sl[k] = SLMV[slp[k*3 +: 3]];
		repeat (6) @(posedge aclk);
		chk_out();
	endtask : cfg

	// One conversion: code offered, window waited out, filter stepped in the model.
	task automatic conv(input logic [7:0] c);
		int i;
		sensor_code <= c;
		for (i = 0; i < 4000 && sensor_enable !== 1'b1; i++) @(posedge aclk);
		for (i = i; i < 4000 && sensor_enable !== 1'b0; i++) @(posedge aclk);
		if (i == 4000) timed_out();
		raw = c;
		if (int'(c) >= int'(filt) + 2) filt++;
		else if (int'(filt) >= int'(c) + 2) filt--;
		repeat (6) @(posedge aclk);
		axi_rd(ADDR_TEMP, {15'h0, 1'b1, filt, raw}, RESP_OKAY);
		chk_out();
	endtask : conv

	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(ADDR_CTRL, 32'h0, RESP_OKAY);
		axi_rd(ADDR_SLOPE, 32'h0, RESP_OKAY);
		axi_rd(ADDR_TEMP, 32'h00004000, RESP_OKAY);
		axi_rd(8'h14, 32'h0, RESP_SLVERR);
		axi_wr(ADDR_TEMP, 32'hFF, RESP_SLVERR);
		axi_rd(ADDR_TEMP, 32'h00004000, RESP_OKAY);
		chk_out();
		$display("test reset done");
		cfg(3'b101, {3'd4, 3'd6, 3'd3, 3'd1}, 8'h80);
		foreach (codes[n]) conv(codes[n]);
		$display("test regions done");
		for (int k = 0; k < 8; k++) cfg(3'b101, {4{3'(k)}}, 8'h80);
		$display("test slopes done");
		cfg(3'b101, {4{3'd4}}, 8'h10);
		cfg(3'b101, {4{3'd7}}, 8'hF0);
		cfg(3'b001, {4{3'd7}}, 8'hF0);
		external_supply <= 1'b1;
		cfg(3'b101, {4{3'd7}}, 8'h80);
		external_supply <= 1'b0;
		$display("test gating done");
		cfg(3'b111, {4{3'd7}}, 8'h80);
		conv(filt + 8'h01);
		conv(filt - 8'h01);
		conv(filt + 8'h03);
		$display("test filter done");
		summarize();
	end
endmodule : lvtc_tb_top
